/* File: inc/amss_regs.vh */
// register map, field layout, reset values and scale figures of the monitor select block
// assumes a word-indexed register port with 4-bit addresses and 16-bit data
`ifndef AMSS_REGS_VH
`define AMSS_REGS_VH

`define AMSS_ADDR_W        4
`define AMSS_DATA_W        16

`define AMSS_ADDR_SEL1     4'h0
`define AMSS_ADDR_SEL2     4'h1
`define AMSS_ADDR_OFS1     4'h2
`define AMSS_ADDR_OFS2     4'h3
`define AMSS_ADDR_MUL1     4'h4
`define AMSS_ADDR_MUL2     4'h5
`define AMSS_ADDR_STAT     4'h6
`define AMSS_ADDR_OUT1     4'h7
`define AMSS_ADDR_OUT2     4'h8

`define AMSS_RST_SEL1      16'h0002
`define AMSS_RST_SEL2      16'h0000
`define AMSS_RST_OFS       16'h0000
`define AMSS_RST_MUL       16'h0064

`define AMSS_CODE_LSB      0
`define AMSS_CODE_MSB      7

`define AMSS_SRC_MSPD      8'h00
`define AMSS_SRC_SREF      8'h01
`define AMSS_SRC_TREF      8'h02
`define AMSS_SRC_PERR      8'h03
`define AMSS_SRC_AERR      8'h04
`define AMSS_SRC_PRSPD     8'h05
`define AMSS_SRC_MLERR     8'h07
`define AMSS_SRC_PCOMP     8'h08
`define AMSS_SRC_SFF       8'h09
`define AMSS_SRC_TFF       8'h0a
`define AMSS_SRC_RCOMP     8'h0c
`define AMSS_SRC_EESPD     8'h0d

`define AMSS_MODE_POS      2'h0
`define AMSS_MODE_SPD      2'h1
`define AMSS_MODE_TRQ      2'h2

// millivolts per input unit; speed in rpm, torque in 0.1 % rated
`define AMSS_MV_SPEED      32'sd1
`define AMSS_MV_SPEED_DD   32'sd10
`define AMSS_MV_TORQUE     32'sd1
`define AMSS_MV_PERR       32'sd50
`define AMSS_MV_AERR       32'sd50
`define AMSS_MV_MLERR      32'sd10
`define AMSS_MV_HIGH       32'sd5000
`define AMSS_MV_PER_OFS    48'sd100
`define AMSS_MUL_DIV       48'sd100
`define AMSS_OUT_MAX       48'sd32767
`define AMSS_OUT_MIN       (-48'sd32768)

`endif

/* File: hdl/amss_scale.v */
// one monitor channel: multiplier, offset, sign inversion and saturation
// assumes signal and settings come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "amss_regs.vh"

module amss_scale (
    input  wire               clk_in,
    input  wire               rst_in,
    input  wire signed [31:0] sig_mv_in,
    input  wire signed [15:0] mul_in,
    input  wire signed [15:0] ofs_in,
    output reg  signed [15:0] volt_mv_out
);

    wire signed [47:0] prod;
    wire signed [47:0] scaled;
    wire signed [47:0] ofs_mv;
    wire signed [47:0] next_sum;

    // multiplier is in hundredths, offset in tenths of a volt
    assign prod     = $signed({{16{sig_mv_in[31]}}, sig_mv_in})
                    * $signed({{32{mul_in[15]}}, mul_in});
    assign scaled   = prod / `AMSS_MUL_DIV;
    assign ofs_mv   = $signed({{32{ofs_in[15]}}, ofs_in}) * `AMSS_MV_PER_OFS;
    assign next_sum = -(scaled + ofs_mv);

    // clipping keeps a large offset from wrapping to the opposite rail
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            volt_mv_out <= 16'sh0000;
        end else if (next_sum > `AMSS_OUT_MAX) begin
            volt_mv_out <= 16'sh7fff;
        end else if (next_sum < `AMSS_OUT_MIN) begin
            volt_mv_out <= 16'sh8000;
        end else begin
            volt_mv_out <= next_sum[15:0];
        end
    end

endmodule
`default_nettype wire

/* File: hdl/amss_monitor.v */
// analog monitor source select: two channels, each picks and scales a loop quantity
// assumes all loop quantities and status come from logic on clk_in
`timescale 1ns/1ps
`default_nettype none
`include "amss_regs.vh"

module amss_monitor #(
    parameter NCH = 2
) (
    input  wire        clk_in,
    input  wire        rst_in,
    input  wire [3:0]  addr_in,
    input  wire [15:0] wdata_in,
    input  wire        wr_in,
    input  wire        rd_in,
    output reg  [15:0] rdata_out,
    input  wire [15:0] motor_speed_in,
    input  wire [15:0] speed_ref_in,
    input  wire [15:0] torque_ref_in,
    input  wire [15:0] pos_err_in,
    input  wire [15:0] amp_err_in,
    input  wire [15:0] pos_ref_speed_in,
    input  wire [15:0] load_err_in,
    input  wire        pos_done_in,
    input  wire [15:0] speed_ff_in,
    input  wire [15:0] torque_ff_in,
    input  wire        ref_done_in,
    input  wire [15:0] ext_speed_in,
    input  wire [1:0]  ctrl_mode_in,
    input  wire        direct_drive_in,
    output wire [15:0] mon_one_mv_out,
    output wire [15:0] mon_two_mv_out
);

    // selector code field width; the rest of each selector word is stored but unused
    localparam CODE_W = `AMSS_CODE_MSB - `AMSS_CODE_LSB + 1;

    reg  [15:0]         monitor_one_source_select;
    reg  [15:0]         monitor_two_source_select;
    reg  [15:0]         monitor_one_offset;
    reg  [15:0]         monitor_two_offset;
    reg  [15:0]         monitor_one_gain;
    reg  [15:0]         monitor_two_gain;
    reg  [16*NCH-1:0]   sel_bus;
    reg  [16*NCH-1:0]   ofs_bus;
    reg  [16*NCH-1:0]   mul_bus;
    wire [16*NCH-1:0]   out_bus;
    reg  [15:0]         next_rdata;

    // sign-extend a loop quantity so every product is taken at full width
    // unsigned ports would otherwise zero-extend and turn negative values positive
    function signed [31:0] amss_sx;
        input [15:0] val;
        begin
            amss_sx = $signed({{16{val[15]}}, val});
        end
    endfunction

    // millivolts per rpm; direct drive steps ten times finer
    function signed [31:0] amss_speed_mv;
        input dd;
        begin
            if (dd) begin
                amss_speed_mv = `AMSS_MV_SPEED_DD;
            end else begin
                amss_speed_mv = `AMSS_MV_SPEED;
            end
        end
    endfunction

    // two-level status output
    function signed [31:0] amss_level_mv;
        input flag;
        begin
            if (flag) begin
                amss_level_mv = `AMSS_MV_HIGH;
            end else begin
                amss_level_mv = 32'sh00000000;
            end
        end
    endfunction

    // raw quantity behind each selector code
    // level, reserved and unlisted codes give zero here
    function [15:0] amss_raw;
        input [7:0] code;
        begin
            case (code)
                `AMSS_SRC_MSPD: begin
                    amss_raw = motor_speed_in;
                end
                `AMSS_SRC_SREF: begin
                    amss_raw = speed_ref_in;
                end
                `AMSS_SRC_TREF: begin
                    amss_raw = torque_ref_in;
                end
                `AMSS_SRC_PERR: begin
                    amss_raw = pos_err_in;
                end
                `AMSS_SRC_AERR: begin
                    amss_raw = amp_err_in;
                end
                `AMSS_SRC_PRSPD: begin
                    amss_raw = pos_ref_speed_in;
                end
                `AMSS_SRC_MLERR: begin
                    amss_raw = load_err_in;
                end
                `AMSS_SRC_SFF: begin
                    amss_raw = speed_ff_in;
                end
                `AMSS_SRC_TFF: begin
                    amss_raw = torque_ff_in;
                end
                `AMSS_SRC_EESPD: begin
                    amss_raw = ext_speed_in;
                end
                default: begin
                    amss_raw = 16'h0000;
                end
            endcase
        end
    endfunction

    // millivolts per unit of each code; zero for codes with no scaled quantity
    function signed [31:0] amss_unit_mv;
        input [7:0] code;
        input       dd;
        input [1:0] mode;
        begin
            case (code)
                `AMSS_SRC_MSPD: begin
                    amss_unit_mv = amss_speed_mv(dd);
                end
                `AMSS_SRC_SREF: begin
                    amss_unit_mv = amss_speed_mv(dd);
                end
                `AMSS_SRC_TREF: begin
                    amss_unit_mv = `AMSS_MV_TORQUE;
                end
                `AMSS_SRC_PERR: begin
                    // position error has no meaning outside position mode
                    if (mode == `AMSS_MODE_POS) begin
                        amss_unit_mv = `AMSS_MV_PERR;
                    end else begin
                        amss_unit_mv = 32'sh00000000;
                    end
                end
                `AMSS_SRC_AERR: begin
                    amss_unit_mv = `AMSS_MV_AERR;
                end
                `AMSS_SRC_PRSPD: begin
                    amss_unit_mv = amss_speed_mv(dd);
                end
                `AMSS_SRC_MLERR: begin
                    amss_unit_mv = `AMSS_MV_MLERR;
                end
                `AMSS_SRC_SFF: begin
                    amss_unit_mv = amss_speed_mv(dd);
                end
                `AMSS_SRC_TFF: begin
                    amss_unit_mv = `AMSS_MV_TORQUE;
                end
                `AMSS_SRC_EESPD: begin
                    amss_unit_mv = amss_speed_mv(dd);
                end
                default: begin
                    amss_unit_mv = 32'sh00000000;
                end
            endcase
        end
    endfunction

    // selector decode, shared by both channels
    function signed [31:0] amss_pick;
        input [7:0] code;
        input       dd;
        input [1:0] mode;
        begin
            case (code)
                `AMSS_SRC_PCOMP: begin
                    amss_pick = amss_level_mv(pos_done_in);
                end
                `AMSS_SRC_RCOMP: begin
                    amss_pick = amss_level_mv(ref_done_in);
                end
                default: begin
                    // reserved codes carry a zero unit, which leaves only the negated offset on the channel
                    amss_pick = amss_sx(amss_raw(code)) * amss_unit_mv(code, dd, mode);
                end
            endcase
        end
    endfunction

    // register writes; settings take effect on the next cycle
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            monitor_one_source_select <= `AMSS_RST_SEL1;
            monitor_two_source_select <= `AMSS_RST_SEL2;
            monitor_one_offset        <= `AMSS_RST_OFS;
            monitor_two_offset        <= `AMSS_RST_OFS;
            monitor_one_gain          <= `AMSS_RST_MUL;
            monitor_two_gain          <= `AMSS_RST_MUL;
        end else if (wr_in) begin
            case (addr_in)
                `AMSS_ADDR_SEL1: begin
                    monitor_one_source_select <= wdata_in;
                end
                `AMSS_ADDR_SEL2: begin
                    monitor_two_source_select <= wdata_in;
                end
                `AMSS_ADDR_OFS1: begin
                    monitor_one_offset <= wdata_in;
                end
                `AMSS_ADDR_OFS2: begin
                    monitor_two_offset <= wdata_in;
                end
                `AMSS_ADDR_MUL1: begin
                    monitor_one_gain <= wdata_in;
                end
                `AMSS_ADDR_MUL2: begin
                    monitor_two_gain <= wdata_in;
                end
                default: begin
                    // read-only and unmapped words ignore writes
                end
            endcase
        end
    end

    // gather per-channel settings so the channel logic can be a loop
    always @* begin
        sel_bus = {monitor_two_source_select, monitor_one_source_select};
        ofs_bus = {monitor_two_offset, monitor_one_offset};
        mul_bus = {monitor_two_gain, monitor_one_gain};
    end

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch = ch + 1) begin : g_ch
            reg  [31:0]       sig_q;
            wire [CODE_W-1:0] chan_code;
            wire [15:0]       chan_mul;
            wire [15:0]       chan_ofs;

            // each channel decodes only its own selector
            assign chan_code = sel_bus[16*ch + `AMSS_CODE_LSB +: CODE_W];
            assign chan_mul  = mul_bus[16*ch +: 16];
            assign chan_ofs  = ofs_bus[16*ch +: 16];

            // one register per channel keeps the decode off the multiplier path
            always @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    sig_q <= 32'h00000000;
                end else begin
                    sig_q <= amss_pick(chan_code, direct_drive_in, ctrl_mode_in);
                end
            end

            amss_scale u_scale (
                .clk_in      (clk_in),
                .rst_in      (rst_in),
                .sig_mv_in   (sig_q),
                .mul_in      (chan_mul),
                .ofs_in      (chan_ofs),
                .volt_mv_out (out_bus[16*ch +: 16])
            );
        end
    endgenerate

    // channel outputs come straight from the scaler flip-flops
    assign mon_one_mv_out = out_bus[15:0];
    assign mon_two_mv_out = out_bus[31:16];

    // read mux; unmapped words read as zero
    always @* begin
        next_rdata = 16'h0000;
        if (rd_in) begin
            case (addr_in)
                `AMSS_ADDR_SEL1: begin
                    next_rdata = monitor_one_source_select;
                end
                `AMSS_ADDR_SEL2: begin
                    next_rdata = monitor_two_source_select;
                end
                `AMSS_ADDR_OFS1: begin
                    next_rdata = monitor_one_offset;
                end
                `AMSS_ADDR_OFS2: begin
                    next_rdata = monitor_two_offset;
                end
                `AMSS_ADDR_MUL1: begin
                    next_rdata = monitor_one_gain;
                end
                `AMSS_ADDR_MUL2: begin
                    next_rdata = monitor_two_gain;
                end
                `AMSS_ADDR_STAT: begin
                    next_rdata = {13'h0000, direct_drive_in, ctrl_mode_in};
                end
                `AMSS_ADDR_OUT1: begin
                    next_rdata = mon_one_mv_out;
                end
                `AMSS_ADDR_OUT2: begin
                    next_rdata = mon_two_mv_out;
                end
                default: begin
                    next_rdata = 16'h0000;
                end
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= 16'h0000;
        end else begin
            rdata_out <= next_rdata;
        end
    end

endmodule
`default_nettype wire

/* File: tb/amss_props.sv */
// checker for the monitor select block: bus answers and scaled channel outputs
// assumes one clock; output checks hold only while gain and offset keep their reset values
`timescale 1ns/1ps
`default_nettype none
module amss_props (
    input wire        clk_in,
    input wire        rst_in,
    input wire [3:0]  addr_in,
    input wire [15:0] wdata_in,
    input wire        wr_in,
    input wire        rd_in,
    input wire [15:0] rdata_out,
    input wire [15:0] motor_speed_in,
    input wire [15:0] torque_ref_in,
    input wire        pos_done_in,
    input wire [1:0]  ctrl_mode_in,
    input wire        direct_drive_in,
    input wire [15:0] mon_one_mv_out,
    input wire [15:0] mon_two_mv_out
);
    reg  [7:0] s1;
    reg  [7:0] s2;
    reg        cust;
    reg  [1:0] up;
    wire       ok = (up == 2'h3) && !cust;
    // shadow selectors; any gain or offset write ends the exact-value checks
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s1 <= 8'h02;
            s2 <= 8'h00;
            cust <= 1'b0;
            up <= 2'h0;
        end else begin
            if (up != 2'h3) up <= up + 2'h1;
            if (wr_in && addr_in == 4'h0) s1 <= wdata_in[7:0];
            if (wr_in && addr_in == 4'h1) s2 <= wdata_in[7:0];
            if (wr_in && addr_in >= 4'h2 && addr_in <= 4'h5) cust <= 1'b1;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    read_idle_a: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
        else $error("read data not idle");
    read_unmapped_a: assert property (rd_in && addr_in > 4'h8 |=> rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    read_status_a: assert property (rd_in && addr_in == 4'h6 |=>
        rdata_out == {13'h0000, $past(direct_drive_in), $past(ctrl_mode_in)})
        else $error("status read wrong");
    read_out_a: assert property (rd_in && addr_in == 4'h7 |=>
        rdata_out == $past(mon_one_mv_out)) else $error("output read wrong");
    speed_two_a: assert property (ok && $past(s2, 2) == 8'h00 && !$past(direct_drive_in, 2)
        && $past(motor_speed_in, 2) < 16'd3000 |->
        mon_two_mv_out == 16'h0000 - $past(motor_speed_in, 2)) else $error("speed scale wrong");
    torque_one_a: assert property (ok && $past(s1, 2) == 8'h02
        && $past(torque_ref_in, 2) < 16'd3000 |->
        mon_one_mv_out == 16'h0000 - $past(torque_ref_in, 2)) else $error("torque scale wrong");
    perr_zero_a: assert property (ok && $past(s1, 2) == 8'h03
        && $past(ctrl_mode_in, 2) != 2'h0 |-> mon_one_mv_out == 16'h0000)
        else $error("position error not zero");
    done_level_a: assert property (ok && $past(s1, 2) == 8'h08 |->
        mon_one_mv_out == ($past(pos_done_in, 2) ? 16'hec78 : 16'h0000))
        else $error("done level wrong");
    dd_speed_a: assert property (ok && $past(s2, 2) == 8'h00 && $past(direct_drive_in, 2)
        && $past(motor_speed_in, 2) < 16'd3000 |->
        mon_two_mv_out == 16'h0000 - 16'd10 * $past(motor_speed_in, 2))
        else $error("direct drive scale wrong");
    cover_dd: cover property (ok && direct_drive_in && s2 == 8'h00);
    cover_done: cover property (ok && s1 == 8'h08 && pos_done_in);
    cover_stat: cover property (rd_in && addr_in == 4'h6);
endmodule
bind amss_monitor amss_props u_amss_props (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .motor_speed_in(motor_speed_in), .torque_ref_in(torque_ref_in),
    .pos_done_in(pos_done_in), .ctrl_mode_in(ctrl_mode_in), .direct_drive_in(direct_drive_in),
    .mon_one_mv_out(mon_one_mv_out), .mon_two_mv_out(mon_two_mv_out));
`default_nettype wire

/* File: tb/amss_recorder.sv */
// recorder model on the monitor connector: captures both channels each clock
// assumes it shares the block clock; it never drives the monitor lines
`timescale 1ns/1ps
`default_nettype none
module amss_recorder (
    input  wire        clk_in,
    input  wire [15:0] one_in,
    input  wire [15:0] two_in,
    output reg  [15:0] one_out,
    output reg  [15:0] two_out
);
    always @(posedge clk_in) begin
        one_out <= one_in;
        two_out <= two_in;
    end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// testbench for the monitor select block: register port tasks and recorder checks
// assumes the recorder adds one clock of delay to what it reports
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    reg         clk_in = 1'b0;
    reg         rst_in = 1'b1;
    reg  [3:0]  addr = 4'h0;
    reg  [15:0] wdata = 16'h0000;
    reg         wr = 1'b0;
    reg         rd = 1'b0;
    reg  [1:0]  mode = 2'h0;
    reg         dd = 1'b0;
    reg         done = 1'b0;
    reg  [15:0] v [0:13];
    wire [15:0] rdata;
    wire [15:0] mon1;
    wire [15:0] mon2;
    wire [15:0] rec1;
    wire [15:0] rec2;
    integer     fail_count = 0;
    integer     checked = 0;
    integer     c;
    integer     m;
    integer     d;
    always #25 clk_in = ~clk_in;
    amss_monitor u_amss_monitor (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .motor_speed_in(v[0]),
        .speed_ref_in(v[1]), .torque_ref_in(v[2]), .pos_err_in(v[3]), .amp_err_in(v[4]),
        .pos_ref_speed_in(v[5]), .load_err_in(v[7]), .pos_done_in(done), .speed_ff_in(v[9]),
        .torque_ff_in(v[10]), .ref_done_in(~done), .ext_speed_in(v[13]), .ctrl_mode_in(mode),
        .direct_drive_in(dd), .mon_one_mv_out(mon1), .mon_two_mv_out(mon2));
    amss_recorder u_amss_recorder (.clk_in(clk_in), .one_in(mon1), .two_in(mon2),
        .one_out(rec1), .two_out(rec2));
    task tally_and_finish;
        begin
            if (fail_count == 0 && checked > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                $display("[ERR] %0t got %h expected %h", $time, got, exp);
                fail_count = fail_count + 1;
            end
        end
    endtask
    task wr_reg(input [3:0] a, input [15:0] dv);
        begin
            @(posedge clk_in);
            wr <= 1'b1;
            addr <= a;
            wdata <= dv;
            @(posedge clk_in);
            wr <= 1'b0;
        end
    endtask
    task rd_reg(input [3:0] a, input [15:0] exp);
        begin
            @(posedge clk_in);
            rd <= 1'b1;
            addr <= a;
            @(posedge clk_in);
            rd <= 1'b0;
            #1 chk(rdata, exp);
        end
    endtask
    // settle time covers the two-stage path plus the recorder stage
    task mon_chk(input [15:0] e1, input [15:0] e2);
        begin
            repeat (4) @(posedge clk_in);
            #1 chk(rec1, e1);
            chk(rec2, e2);
        end
    endtask
    function [15:0] expv(input integer cd);
        integer k;
        begin
            case (cd)
                0, 1, 5, 9, 13: k = dd ? 10 : 1;
                2, 10: k = 1;
                3: k = (mode == 2'h0) ? 50 : 0;
                4: k = 50;
                7: k = 10;
                default: k = 0;
            endcase
            expv = 16'h0000 - k * v[cd];
            if (cd == 8) expv = done ? 16'hec78 : 16'h0000;
            if (cd == 12) expv = done ? 16'h0000 : 16'hec78;
        end
    endfunction
    initial begin
        for (c = 0; c < 14; c = c + 1) v[c] = 16'd100 * (c + 1);
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        rd_reg(4'h0, 16'h0002);
        rd_reg(4'h1, 16'h0000);
        rd_reg(4'h4, 16'h0064);
        rd_reg(4'h3, 16'h0000);
        rd_reg(4'h9, 16'h0000);
        mon_chk(16'hfed4, 16'hff9c);
        wr_reg(4'h6, 16'hffff);
        rd_reg(4'h6, 16'h0000);
        for (m = 0; m < 4; m = m + 1) begin
            for (d = 0; d < 2; d = d + 1) begin
                @(posedge clk_in);
                mode <= m[1:0];
                dd <= d[0];
                done <= m[0];
                for (c = 0; c < 14; c = c + 1) begin
                    wr_reg(4'h0, c[15:0]);
                    wr_reg(4'h1, 16'd13 - c[15:0]);
                    mon_chk(expv(c), expv(13 - c));
                end
                rd_reg(4'h6, {13'h0000, d[0], m[1:0]});
                rd_reg(4'h7, expv(13));
            end
        end
        @(posedge clk_in);
        mode <= 2'h0;
        dd <= 1'b0;
        wr_reg(4'h0, 16'h0002);
        wr_reg(4'h4, 16'd200);
        wr_reg(4'h2, 16'd5);
        wr_reg(4'h1, 16'h0000);
        wr_reg(4'h5, 16'hff9c);
        wr_reg(4'h3, 16'hfffd);
        mon_chk(16'hfbb4, 16'h0190);
        wr_reg(4'h4, 16'd10000);
        wr_reg(4'h0, 16'h0009);
        mon_chk(16'h8000, 16'h0190);
        rd_reg(4'h7, 16'h8000);
        tally_and_finish;
    end
    // whole run is near 1000 clocks; the limit leaves ample margin
    initial begin
        repeat (6000) @(posedge clk_in);
        fail_count = fail_count + 1;
        tally_and_finish;
    end
endmodule
`default_nettype wire
